// [design/evp_consts.vh]
`ifndef EVP_CONSTS_VH
`define EVP_CONSTS_VH
`define EVP_VEC_RESET   5'h00
`define EVP_VEC_NMI     5'h07
`define EVP_VEC_TRAP0   5'h08
`define EVP_VEC_BREAK   5'h0C
`define EVP_VEC_DIRECT  5'h0D
`define EVP_VEC_PIN_A   5'h0E
`define EVP_VEC_PIN_D   5'h11
`define EVP_VEC_WAKEUP  5'h12
`define EVP_VEC_TIMER1  5'h15
`define EVP_VEC_TIMER2  5'h16
`define EVP_VEC_SERIAL  5'h17
`define EVP_VEC_CONV    5'h19
`define EVP_NUM_SRC     12
`define EVP_ENA_DIRECT_BIT 7
`define EVP_ENA_WAKEUP_BIT 5
`define EVP_ENA_PIN_D_BIT  3
`define EVP_ENA_PIN_A_BIT  0
`define EVP_CCR_MASK_BIT   7
`define EVP_EDGE_PIN_D_BIT 3
`define EVP_EDGE_PIN_A_BIT 0
`endif

// [design/evp_edge_detect.v]
`timescale 1ns/1ns
`include "evp_consts.vh"
module evp_edge_detect #(
    parameter WIDTH = 8
) (
    input  wire             i_core_clk,
    input  wire             i_arst_n,
    input  wire [WIDTH-1:0] i_pin,
    input  wire [WIDTH-1:0] i_rising,
    output reg  [WIDTH-1:0] o_edge
);
    reg [WIDTH-1:0] sync_a;
    reg [WIDTH-1:0] sync_b;
    reg [WIDTH-1:0] last;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                    last[g]   <= 1'b0;
                    o_edge[g] <= 1'b0;
                end else begin
                    sync_a[g] <= i_pin[g];
                    sync_b[g] <= sync_a[g];
                    last[g]   <= sync_b[g];
                    // select 0 falling, 1 rising
                    o_edge[g] <= i_rising[g] ? (sync_b[g] & ~last[g])
                                             : (~sync_b[g] & last[g]);
                end
            end
        end
    endgenerate
endmodule

// [design/evp_exception_vector.v]
`timescale 1ns/1ns
`include "evp_consts.vh"
module evp_exception_vector (
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    input  wire       i_watchdog_overflow,
    input  wire       i_software_trap_call,
    input  wire [1:0] i_trap_code,
    input  wire       i_nmi_pin,
    input  wire       i_nmi_rising,
    input  wire       i_break_req,
    input  wire       i_direct_transition_req,
    input  wire       i_ext_request_pin_a,
    input  wire       i_ext_request_pin_d,
    input  wire [5:0] i_wakeup_pin_group,
    input  wire [7:0] i_condition_code_reg,
    input  wire [7:0] i_int_enable,
    input  wire [7:0] i_edge_select,
    input  wire [5:0] i_wakeup_edge_select,
    input  wire [4:0] i_timer1_req,
    input  wire [2:0] i_timer2_req,
    input  wire [3:0] i_serial_comm_unit_req,
    input  wire       i_conv_done_req,
    input  wire       i_boundary,
    input  wire       i_ack,
    output wire       o_exc_valid,
    output reg  [4:0] o_vector_num,
    output reg  [15:0] o_vector_addr,
    output reg  [5:0] o_wakeup_flags,
    output reg  [1:0] o_pin_flags,
    output reg        o_nmi_flag,
    output reg        o_reset_pending
);
    // source index order equals priority order
    localparam S_NMI = 0, S_TRAP = 1, S_BRK = 2, S_DIR = 3, S_PA = 4, S_PD = 5;
    localparam S_WK = 6, S_T1 = 7, S_T2 = 8, S_SER = 9, S_CNV = 10;
    localparam ST_RUN = 3'b001, ST_HOLD = 3'b010, ST_RESET = 3'b100;
    reg        rst_s1;
    reg        rst_s2;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [1:0] trap_code;
    reg        trap_pend;
    reg        brk_pend;
    reg        dir_pend;
    wire [8:0] pin_edges;
    wire [10:0] pend;
    wire [10:0] masked;
    wire        mask_flag;
    reg  [4:0]  next_vec;
    reg         next_any;
    integer     k;

    function [4:0] evp_src_vec;
        input [3:0] idx;
        input [1:0] code;
        begin
            case (idx)
                4'h0:    evp_src_vec = `EVP_VEC_NMI;
                4'h1:    evp_src_vec = `EVP_VEC_TRAP0 + {3'h0, code};
                4'h2:    evp_src_vec = `EVP_VEC_BREAK;
                4'h3:    evp_src_vec = `EVP_VEC_DIRECT;
                4'h4:    evp_src_vec = `EVP_VEC_PIN_A;
                4'h5:    evp_src_vec = `EVP_VEC_PIN_D;
                4'h6:    evp_src_vec = `EVP_VEC_WAKEUP;
                4'h7:    evp_src_vec = `EVP_VEC_TIMER1;
                4'h8:    evp_src_vec = `EVP_VEC_TIMER2;
                4'h9:    evp_src_vec = `EVP_VEC_SERIAL;
                default: evp_src_vec = `EVP_VEC_CONV;
            endcase
        end
    endfunction

    evp_edge_detect #(.WIDTH(9)) u_edges (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      ({i_nmi_pin, i_wakeup_pin_group, i_ext_request_pin_d,
                      i_ext_request_pin_a}),
        .i_rising   ({i_nmi_rising, i_wakeup_edge_select,
                      i_edge_select[`EVP_EDGE_PIN_D_BIT],
                      i_edge_select[`EVP_EDGE_PIN_A_BIT]}),
        .o_edge     (pin_edges)
    );

    // reset pin synchroniser: release seen two edges later
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    assign mask_flag = i_condition_code_reg[`EVP_CCR_MASK_BIT];
    wire take = (state == ST_RUN) && i_boundary && next_any;
    wire serve_reset = (state == ST_RESET) && rst_s2;

    // sticky flags; a new event beats the service clear of the same cycle, but not a reset or watchdog clear
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_nmi_flag     <= 1'b0;
            o_pin_flags    <= 2'h0;
            o_wakeup_flags <= 6'h00;
            trap_pend      <= 1'b0;
            trap_code      <= 2'h0;
            brk_pend       <= 1'b0;
            dir_pend       <= 1'b0;
        end else if (state == ST_RESET || i_watchdog_overflow) begin
            o_nmi_flag     <= 1'b0;
            o_pin_flags    <= 2'h0;
            o_wakeup_flags <= 6'h00;
            trap_pend      <= 1'b0;
            brk_pend       <= 1'b0;
            dir_pend       <= 1'b0;
        end else begin
            o_nmi_flag <= pin_edges[8] |
                          (o_nmi_flag & ~(take && next_vec == `EVP_VEC_NMI));
            o_pin_flags[0] <= pin_edges[0] |
                (o_pin_flags[0] & ~(take && next_vec == `EVP_VEC_PIN_A));
            o_pin_flags[1] <= pin_edges[1] |
                (o_pin_flags[1] & ~(take && next_vec == `EVP_VEC_PIN_D));
            // whole group cleared when its shared vector is served
            o_wakeup_flags <= pin_edges[7:2] |
                (o_wakeup_flags & ~{6{take && next_vec == `EVP_VEC_WAKEUP}});
            if (i_software_trap_call) begin
                trap_pend <= 1'b1;
                trap_code <= i_trap_code;
            end else if (take && next_vec[4:2] == 3'h2) begin
                trap_pend <= 1'b0;
            end
            brk_pend <= i_break_req | (brk_pend & ~(take && next_vec == `EVP_VEC_BREAK));
            dir_pend <= (i_direct_transition_req & i_int_enable[`EVP_ENA_DIRECT_BIT]) |
                        (dir_pend & ~(take && next_vec == `EVP_VEC_DIRECT));
        end
    end

    assign pend[S_NMI]  = o_nmi_flag;
    assign pend[S_TRAP] = trap_pend;
    assign pend[S_BRK]  = brk_pend;
    assign pend[S_DIR]  = dir_pend;
    assign pend[S_PA]   = o_pin_flags[0] & i_int_enable[`EVP_ENA_PIN_A_BIT];
    assign pend[S_PD]   = o_pin_flags[1] & i_int_enable[`EVP_ENA_PIN_D_BIT];
    assign pend[S_WK]   = (|o_wakeup_flags) & i_int_enable[`EVP_ENA_WAKEUP_BIT];
    assign pend[S_T1]   = |i_timer1_req;
    assign pend[S_T2]   = |i_timer2_req;
    assign pend[S_SER]  = |i_serial_comm_unit_req;
    assign pend[S_CNV]  = i_conv_done_req;

    // nmi, trap and break pass the mask; the rest wait while it is one
    assign masked = pend & {{8{~mask_flag}}, 1'b1, 1'b1, 1'b1};

    // lowest index wins, giving vector order priority
    always @* begin
        next_vec = `EVP_VEC_CONV;
        next_any = 1'b0;
        for (k = `EVP_NUM_SRC - 2; k >= 0; k = k - 1) begin
            if (masked[k]) begin
                next_vec = evp_src_vec(k[3:0], trap_code);
                next_any = 1'b1;
            end
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_RESET: if (rst_s2 && i_ack) next_state = ST_RUN;
            ST_RUN:   if (take) next_state = ST_HOLD;
            ST_HOLD:  if (i_ack) next_state = ST_RUN;
            default:  next_state = ST_RESET;
        endcase
        if (i_watchdog_overflow) begin
            next_state = ST_RESET;
        end
    end

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state           <= ST_RESET;
            o_vector_num    <= `EVP_VEC_RESET;
            o_vector_addr   <= 16'h0000;
            o_reset_pending <= 1'b1;
        end else begin
            state           <= next_state;
            o_reset_pending <= (next_state == ST_RESET);
            if (i_watchdog_overflow || next_state == ST_RESET) begin
                o_vector_num  <= `EVP_VEC_RESET;
                o_vector_addr <= 16'h0000;
            end else if (take) begin
                o_vector_num  <= next_vec;
                o_vector_addr <= {10'h000, next_vec, 1'b0};
            end
        end
    end

    // reset served first; nothing else offered before it is taken
    assign o_exc_valid = serve_reset | (state == ST_HOLD);
endmodule

// [verif/evp_exception_vector_props.sv]
`timescale 1ns/1ns
module evp_exception_vector_props (
    input wire        i_core_clk,
    input wire        i_arst_n,
    input wire        i_watchdog_overflow,
    input wire [7:0]  i_condition_code_reg,
    input wire        i_boundary,
    input wire        i_ack,
    input wire        o_exc_valid,
    input wire [4:0]  o_vector_num,
    input wire [15:0] o_vector_addr,
    input wire        o_reset_pending
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    property p_release;
        $rose(i_arst_n) |-> ##[0:3] (o_exc_valid && o_vector_num == 5'h00);
    endproperty
    a_release: assert property (p_release) else $error("no reset vector after release");
    property p_reset_vec;
        o_reset_pending |-> o_vector_num == 5'h00 && o_vector_addr == 16'h0000;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector not zero");
    property p_wdog;
        i_watchdog_overflow |=> o_reset_pending && o_vector_num == 5'h00;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog did not reset");
    property p_mask;
        $rose(o_exc_valid) && $past(i_condition_code_reg[7]) |-> o_vector_num <= 5'h0C;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source offered");
    property p_boundary;
        $rose(o_exc_valid) |-> $past(i_boundary) || o_vector_num == 5'h00;
    endproperty
    a_boundary: assert property (p_boundary) else $error("offer off boundary");
    property p_stand;
        o_exc_valid && !i_ack && !i_watchdog_overflow |=> o_exc_valid && $stable(o_vector_num);
    endproperty
    a_stand: assert property (p_stand) else $error("offer changed before ack");
    property p_drop;
        o_exc_valid && i_ack && !i_watchdog_overflow |=> !o_exc_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("offer kept after ack");
    property p_addr;
        o_exc_valid |-> o_vector_addr == {10'h000, o_vector_num, 1'h0};
    endproperty
    a_addr: assert property (p_addr) else $error("address not twice number");
endmodule
bind evp_exception_vector evp_exception_vector_props u_evp_exception_vector_props (
    .i_core_clk, .i_arst_n, .i_watchdog_overflow, .i_condition_code_reg, .i_boundary,
    .i_ack, .o_exc_valid, .o_vector_num, .o_vector_addr, .o_reset_pending);

// [verif/evp_core_model.sv]
`timescale 1ns/1ns
module evp_core_model (
    input  wire       i_core_clk,
    input  wire       i_arst_n,
    input  wire       i_exc_valid,
    input  wire       i_stall,
    input  wire       i_slow,
    output wire       o_boundary,
    output reg        o_ack
);
    reg [2:0] wait_cnt;
    // a stalled core is mid-instruction, so no boundary is reported
    assign o_boundary = ~i_stall;
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack    <= 1'h0;
            wait_cnt <= 3'h0;
        end else if (i_exc_valid && !o_ack) begin
            wait_cnt <= wait_cnt + 3'h1;
            o_ack    <= !i_slow || wait_cnt == 3'h3;
        end else begin
            o_ack    <= 1'h0;
            wait_cnt <= 3'h0;
        end
    end
endmodule

// [verif/test_evp_exception_vector.sv]
`timescale 1ns/1ns
`define CHK(nm, ex, sv) begin checked++; if ((sv) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, sv); end end
module test_evp_exception_vector;
    typedef struct packed {
        logic mask; logic [7:0] en; logic [8:0] pins; logic [12:0] lvl; logic [3:0] op;
        logic [4:0] exp;
    } evp_row_t;
    // pins {nmi, a, d, wakeup}; lvl {timer1, timer2, serial, conv}; op {kind, code}
    evp_row_t rows [15] = '{
        '{1'h1, 8'h00, 9'h07F, 13'h0000, 4'h4, 5'h08}, '{1'h1, 8'h00, 9'h07F, 13'h0000, 4'h7, 5'h0B},
        '{1'h1, 8'h00, 9'h07F, 13'h1F00, 4'h8, 5'h0C}, '{1'h1, 8'h00, 9'h07F, 13'h0100, 4'h0, 5'h1F},
        '{1'h0, 8'h00, 9'h07F, 13'h0100, 4'h0, 5'h15}, '{1'h0, 8'h80, 9'h07F, 13'h0100, 4'hC, 5'h0D},
        '{1'h0, 8'h00, 9'h07F, 13'h0080, 4'hC, 5'h16}, '{1'h0, 8'h01, 9'h0FF, 13'h0022, 4'h0, 5'h0E},
        '{1'h0, 8'h08, 9'h0BF, 13'h0000, 4'h0, 5'h11}, '{1'h0, 8'h20, 9'h0BE, 13'h0000, 4'h0, 5'h12},
        '{1'h0, 8'h00, 9'h0BE, 13'h0010, 4'h0, 5'h17}, '{1'h0, 8'h00, 9'h0BE, 13'h0049, 4'h0, 5'h16},
        '{1'h0, 8'h00, 9'h0BE, 13'h0005, 4'h0, 5'h17}, '{1'h0, 8'h00, 9'h0BE, 13'h0001, 4'h0, 5'h19},
        '{1'h1, 8'h00, 9'h1BE, 13'h0200, 4'h0, 5'h07}};
    evp_row_t    r = '{1'h0, 8'h00, 9'h07F, 13'h0000, 4'h0, 5'h00};
    logic        core_clk = 1'h0;
    logic        arst_n = 1'h0;
    logic        wdog = 1'h0;
    logic        pls = 1'h0;
    logic        stall = 1'h1;
    logic        slow = 1'h0;
    logic [7:0]  esel = 8'h01;
    logic [5:0]  wsel = 6'h00;
    wire         bnd;
    wire         ack;
    wire         o_exc_valid;
    wire [4:0]   o_vector_num;
    wire [15:0]  o_vector_addr;
    wire [8:0]   flags;
    wire         rst_pend;
    int          err_count = 0;
    int          checked = 0;
    always #10 core_clk = ~core_clk;
    evp_exception_vector u_evp_exception_vector (.i_core_clk(core_clk), .i_arst_n(arst_n),
        .i_watchdog_overflow(wdog), .i_software_trap_call(pls && r.op[3:2] == 2'h1),
        .i_trap_code(r.op[1:0]), .i_nmi_pin(r.pins[8]), .i_nmi_rising(1'h1),
        .i_break_req(pls && r.op[3:2] == 2'h2), .i_direct_transition_req(pls && r.op[3:2] == 2'h3),
        .i_ext_request_pin_a(r.pins[7]), .i_ext_request_pin_d(r.pins[6]),
        .i_wakeup_pin_group(r.pins[5:0]), .i_condition_code_reg({r.mask, 7'h00}),
        .i_int_enable(r.en), .i_edge_select(esel), .i_wakeup_edge_select(wsel),
        .i_timer1_req(r.lvl[12:8]), .i_timer2_req(r.lvl[7:5]), .i_serial_comm_unit_req(r.lvl[4:1]),
        .i_conv_done_req(r.lvl[0]), .i_boundary(bnd), .i_ack(ack), .o_exc_valid(o_exc_valid),
        .o_vector_num(o_vector_num), .o_vector_addr(o_vector_addr),
        .o_wakeup_flags(flags[5:0]),
        .o_pin_flags(flags[7:6]), .o_nmi_flag(flags[8]), .o_reset_pending(rst_pend));
    evp_core_model u_evp_core_model (.i_core_clk(core_clk), .i_arst_n(arst_n),
        .i_exc_valid(o_exc_valid), .i_stall(stall), .i_slow(slow), .o_boundary(bnd), .o_ack(ack));
    task report_and_stop;
        begin
            $display("checked %0d err_count %0d", checked, err_count);
            if (err_count == 0 && checked > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task wait_for(input logic v, input bit must);
        int n;
        begin
            n = 0;
            while (o_exc_valid !== v && n < 20) begin
                @(negedge core_clk);
                n++;
            end
            if (o_exc_valid !== v && must) begin
                err_count++;
                report_and_stop;
            end
        end
    endtask
    // 5'h1F means nothing may be offered
    task serve(input logic [4:0] e);
        begin
            stall = 1'h0;
            wait_for(1'h1, e != 5'h1F);
            if (e == 5'h1F) begin
                `CHK("masked offer", 1'h0, o_exc_valid)
            end else begin
                `CHK("vector number", e, o_vector_num)
                `CHK("vector address", ({10'h000, e, 1'h0}), o_vector_addr)
                stall = 1'h1;
                r.lvl = 13'h0000;
                wait_for(1'h0, 1'h1);
            end
            stall = 1'h1;
        end
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'h1;
        serve(5'h00);
        for (int i = 0; i < 15; i++) begin
            stall = 1'h1;
            slow = i[0];
            r = rows[i];
            pls = 1'h1;
            @(negedge core_clk);
            pls = 1'h0;
            repeat (6) @(negedge core_clk);
            `CHK("offer inside instruction", 1'h0, o_exc_valid)
            serve(rows[i].exp);
        end
        // pin a now falling, wakeup 0 rising; disabled sources stay flagged, not served
        esel = 8'h00;
        wsel = 6'h01;
        r.mask = 1'h0;
        r.pins = 9'h13D;
        repeat (7) @(negedge core_clk);
        `CHK("flags", 9'h043, flags)
        serve(5'h1F);
        r.lvl = 13'h0100;
        wdog = 1'h1;
        @(negedge core_clk);
        wdog = 1'h0;
        serve(5'h00);
        `CHK("flags after watchdog", 9'h000, flags)
        // reset pin asserted mid-run with a source pending and a boundary open
        r.lvl = 13'h0100;
        stall = 1'h0;
        arst_n = 1'h0;
        repeat (3) @(negedge core_clk);
        `CHK("offer during reset", 1'h0, o_exc_valid)
        `CHK("reset pending", 1'h1, rst_pend)
        arst_n = 1'h1;
        serve(5'h00);
        `CHK("reset pending", 1'h0, rst_pend)
        `CHK("flags after reset", 9'h000, flags)
        report_and_stop;
    end
endmodule
